// File: lqt_pkg.sv
// shared constants and types of the link quality test pattern source
package lqt_pkg;
	localparam int LQT_CLK_HZ = 125_000_000;
	localparam int LQT_SYM_W = 8;
	localparam int LQT_LANE_W = LQT_SYM_W + 1;
	localparam logic [7:0] LQT_D10_2 = 8'h4A;
	localparam logic [7:0] LQT_SEM_DATA = 8'h00;
	localparam logic [7:0] LQT_BLANK_START = 8'hBC;
	localparam logic [7:0] LQT_SCR_RESET = 8'h1C;
	localparam logic [7:0] LQT_BLANK_END = 8'hFB;
	localparam logic [12:0] LQT_BS_LAST = 13'h1FFF;
	localparam logic [8:0] LQT_SR_LAST = 9'h1FF;
	localparam logic [15:0] LQT_SCR_SEED = 16'hFFFF;
	localparam logic [15:0] LQT_SCR_TAPS = 16'h0039;
	localparam logic [6:0] LQT_PRBS_SEED = 7'h7F;
	localparam logic [1:0] LQT_MODE_OFF = 2'h0;
	localparam logic [1:0] LQT_MODE_NYQ = 2'h1;
	localparam logic [1:0] LQT_MODE_SEM = 2'h2;
	localparam logic [1:0] LQT_MODE_PRBS = 2'h3;
	localparam int LQT_SEL_LSB = 2;
	localparam longint LQT_MEASURE_SEC = 10;
	localparam longint LQT_MEASURE_CYC = LQT_MEASURE_SEC * longint'(LQT_CLK_HZ);
	localparam longint LQT_SER_SCALE = longint'(LQT_CLK_HZ) * 1000;
	localparam logic [8:0] LQT_RATE_HBR = 9'h10E;
	localparam logic [8:0] LQT_RATE_RBR = 9'h0A2;
	localparam logic [6:0] LQT_DIV_LAST = 7'h47;
	typedef enum logic [2:0] {
		LQT_IDLE = 3'b000,
		LQT_SHOW = 3'b001,
		LQT_RUN = 3'b010,
		LQT_READ = 3'b011,
		LQT_DIV = 3'b100,
		LQT_DONE = 3'b101
	} lqt_state_t;
endpackage

// File: lqt_stream_if.sv
// valid/ready stream carrying all lane symbols together
`timescale 1ns/1ps
interface lqt_stream_if #(parameter int W = 36) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface // lqt_stream_if

// File: lqt_fifo.sv
// small symbol fifo with a registered read stage
`timescale 1ns/1ps
module lqt_fifo import lqt_pkg::*; #(
	parameter int W = 36,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	lqt_stream_if.snk wr,
	lqt_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("fifo depth must be a power of two");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic [W-1:0] dout_r, dout_nxt;
	logic dval_r, dval_nxt;
	logic push, pop;
	assign wr.ready = (cnt_r < (AW+1)'(DEPTH));
	assign rd.data = dout_r;
	assign rd.valid = dval_r;
	always_comb begin
		push = wr.valid && wr.ready;
		pop = (cnt_r != '0) && (!dval_r || rd.ready);
		wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
		rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		dout_nxt = pop ? mem[rptr_r] : dout_r;
		dval_nxt = pop ? 1'b1 : (rd.ready ? 1'b0 : dval_r);
	end
	always_ff @(posedge clk) begin
		if (push)
			mem[wptr_r] <= wr.data;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
			dout_r <= '0;
			dval_r <= 1'b0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
			dout_r <= dout_nxt;
			dval_r <= dval_nxt;
		end
	end
	a_fifo_bound: assert property (@(posedge clk) disable iff (reset)
		cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // lqt_fifo

// File: lqt_pattern_gen.sv
// link quality test pattern source with symbol error rate computation
//
// Contract
// - nyquist mode: unscrambled D10.2 on every lane
// - announce nyquist as 01 in select bits 3:2
// - error mode: scrambled 00h on each lane
// - blank start once per 8192 symbols
// - every 512th blank start becomes scrambler reset
// - read lane tallies, derive approximate error rate
// - wait ten to hundred seconds before reading
// - rate is count over 0.27 or 0.162 times seconds
// - offer prbs7 pattern, selected via config byte
// - each lane is byte plus control flag
// - one to four lanes, all carried together in one stream
`timescale 1ns/1ps
module lqt_pattern_gen import lqt_pkg::*; #(
	parameter int MAX_LANES = 4,
	parameter int FIFO_DEPTH = 4,
	parameter longint MEASURE_CYCLES = LQT_MEASURE_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic stop,
	input wire logic [1:0] test_mode,
	input wire logic [2:0] lane_count,
	input wire logic rate_hbr,
	output logic [MAX_LANES*LQT_SYM_W-1:0] phy_data,
	output logic [MAX_LANES-1:0] phy_ctrl,
	output logic phy_valid,
	input wire logic phy_ready,
	output logic [7:0] sel_byte,
	output logic sel_upd,
	output logic tally_req,
	output logic [1:0] tally_lane,
	input wire logic tally_valid,
	input wire logic [15:0] tally_value,
	output logic [31:0] ser_value,
	output logic ser_done,
	output logic busy
);
	localparam int WW = MAX_LANES * LQT_LANE_W;
	initial begin
		if (MAX_LANES < 1 || MAX_LANES > 4)
			$error("lane count must be 1 to 4");
		if (MEASURE_CYCLES < 2 || MEASURE_CYCLES >= 64'h100_0000_0000)
			$error("measurement period out of counter range");
	end

	// scrambler: x^16+x^5+x^4+x^3+1, eight steps per symbol
	function automatic logic [23:0] lqt_scr8(input logic [15:0] s);
		logic [15:0] st;
		logic [7:0] m;
		st = s;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			m[i] = st[15];
			st = {st[14:0], 1'b0} ^ (st[15] ? LQT_SCR_TAPS : 16'h0000);
		end
		return {st, m};
	endfunction

	// prbs7: x^7+x^6+1, eight bits per symbol
	function automatic logic [14:0] lqt_prbs8(input logic [6:0] p);
		logic [6:0] st;
		logic [7:0] b;
		st = p;
		b = '0;
		for (int i = 0; i < 8; i++) begin
			b[i] = st[6] ^ st[5];
			st = {st[5:0], b[i]};
		end
		return {st, b};
	endfunction

	lqt_stream_if #(.W(WW)) gen_if ();
	lqt_stream_if #(.W(WW)) out_if ();

	// control, tally read and divider state
	lqt_state_t state_r, state_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [2:0] lanes_r, lanes_nxt;
	logic hbr_r, hbr_nxt;
	logic [7:0] sel_r, sel_nxt;
	logic sel_upd_r, sel_upd_nxt;
	logic [39:0] cyc_r, cyc_nxt;
	logic req_r, req_nxt;
	logic [1:0] lane_idx_r, lane_idx_nxt;
	logic [31:0] err_r, err_nxt;
	logic [71:0] num_r, num_nxt;
	logic [51:0] den_r, den_nxt;
	logic [51:0] rem_r, rem_nxt;
	logic [6:0] dcnt_r, dcnt_nxt;
	logic [31:0] ser_r, ser_nxt;
	logic done_r, done_nxt;
	logic [52:0] rem_sh;
	logic lanes_ok;
	// registered so the busy pin has no decode glitch
	logic busy_r, busy_nxt;

	always_comb begin
		state_nxt = state_r;
		mode_nxt = mode_r;
		lanes_nxt = lanes_r;
		hbr_nxt = hbr_r;
		sel_nxt = sel_r;
		sel_upd_nxt = 1'b0;
		cyc_nxt = cyc_r;
		req_nxt = req_r;
		lane_idx_nxt = lane_idx_r;
		err_nxt = err_r;
		num_nxt = num_r;
		den_nxt = den_r;
		rem_nxt = rem_r;
		dcnt_nxt = dcnt_r;
		ser_nxt = ser_r;
		done_nxt = 1'b0;
		rem_sh = {rem_r, num_r[71]};
		lanes_ok = (lane_count != 3'h0) && (lane_count <= 3'(MAX_LANES));
		case (state_r)
			LQT_IDLE: begin
				if (start && test_mode != LQT_MODE_OFF && lanes_ok) begin
					mode_nxt = test_mode;
					lanes_nxt = lane_count;
					hbr_nxt = rate_hbr;
					sel_nxt = 8'(test_mode) << LQT_SEL_LSB;
					sel_upd_nxt = 1'b1;
					cyc_nxt = '0;
					err_nxt = '0;
					state_nxt = (test_mode == LQT_MODE_SEM) ? LQT_RUN : LQT_SHOW;
				end
			end
			LQT_SHOW: begin
			end
			LQT_RUN: begin
				cyc_nxt = cyc_r + 40'h1;
				if (cyc_r == 40'(MEASURE_CYCLES - 1)) begin
					state_nxt = LQT_READ;
					lane_idx_nxt = '0;
					req_nxt = 1'b1;
				end
			end
			LQT_READ: begin
				if (tally_valid) begin
					err_nxt = err_r + 32'(tally_value);
					if (3'(lane_idx_r) == lanes_r - 3'h1) begin
						req_nxt = 1'b0;
						state_nxt = LQT_DIV;
						// count*clk_hz*1000 / (cycles*270 or 162)
						num_nxt = 72'(err_nxt) * 72'(LQT_SER_SCALE);
						den_nxt = 52'(cyc_r) * 52'(hbr_r ? LQT_RATE_HBR : LQT_RATE_RBR);
						rem_nxt = '0;
						dcnt_nxt = '0;
					end else begin
						lane_idx_nxt = lane_idx_r + 2'h1;
					end
				end
			end
			LQT_DIV: begin
				// restoring division, one quotient bit a cycle
				if (rem_sh >= {1'b0, den_r}) begin
					rem_nxt = 52'(rem_sh - {1'b0, den_r});
					num_nxt = {num_r[70:0], 1'b1};
				end else begin
					rem_nxt = rem_sh[51:0];
					num_nxt = {num_r[70:0], 1'b0};
				end
				dcnt_nxt = dcnt_r + 7'h1;
				if (dcnt_r == LQT_DIV_LAST) begin
					// saturate rather than wrap on absurd counts
					ser_nxt = (num_nxt[71:32] != '0) ? 32'hFFFF_FFFF : num_nxt[31:0];
					done_nxt = 1'b1;
					state_nxt = LQT_DONE;
				end
			end
			LQT_DONE: begin
			end
			default: begin
				state_nxt = LQT_IDLE;
			end
		endcase
		if (stop && state_r != LQT_IDLE) begin
			state_nxt = LQT_IDLE;
			req_nxt = 1'b0;
			sel_nxt = '0;
			sel_upd_nxt = 1'b1;
			done_nxt = 1'b0;
		end
		busy_nxt = (state_nxt != LQT_IDLE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= LQT_IDLE;
			mode_r <= LQT_MODE_OFF;
			lanes_r <= '0;
			hbr_r <= 1'b0;
			sel_r <= '0;
			sel_upd_r <= 1'b0;
			cyc_r <= '0;
			req_r <= 1'b0;
			lane_idx_r <= '0;
			err_r <= '0;
			num_r <= '0;
			den_r <= '0;
			rem_r <= '0;
			dcnt_r <= '0;
			ser_r <= '0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mode_r <= mode_nxt;
			lanes_r <= lanes_nxt;
			hbr_r <= hbr_nxt;
			sel_r <= sel_nxt;
			sel_upd_r <= sel_upd_nxt;
			cyc_r <= cyc_nxt;
			req_r <= req_nxt;
			lane_idx_r <= lane_idx_nxt;
			err_r <= err_nxt;
			num_r <= num_nxt;
			den_r <= den_nxt;
			rem_r <= rem_nxt;
			dcnt_r <= dcnt_nxt;
			ser_r <= ser_nxt;
			done_r <= done_nxt;
			busy_r <= busy_nxt;
		end
	end

	// pattern generator state
	logic [15:0] lfsr_r, lfsr_nxt;
	logic [6:0] prbs_r, prbs_nxt;
	logic [12:0] sym_cnt_r, sym_cnt_nxt;
	logic [8:0] bs_cnt_r, bs_cnt_nxt;
	logic [7:0] sym_data;
	logic sym_ctrl;
	logic active, fire;
	logic [23:0] scr;
	logic [14:0] prb;

	always_comb begin
		active = (state_r != LQT_IDLE);
		fire = active && gen_if.ready;
		scr = lqt_scr8(lfsr_r);
		prb = lqt_prbs8(prbs_r);
		sym_data = '0;
		sym_ctrl = 1'b0;
		case (mode_r)
			LQT_MODE_NYQ: begin
				sym_data = LQT_D10_2;
			end
			LQT_MODE_SEM: begin
				if (sym_cnt_r == '0) begin
					sym_ctrl = 1'b1;
					sym_data = (bs_cnt_r == LQT_SR_LAST) ? LQT_SCR_RESET : LQT_BLANK_START;
				end else begin
					sym_data = LQT_SEM_DATA ^ scr[7:0];
				end
			end
			LQT_MODE_PRBS: begin
				sym_data = prb[7:0];
			end
			default: begin
				sym_data = '0;
			end
		endcase
		lfsr_nxt = lfsr_r;
		prbs_nxt = prbs_r;
		sym_cnt_nxt = sym_cnt_r;
		bs_cnt_nxt = bs_cnt_r;
		if (!active) begin
			// every run starts from the seed, so the sink, reseeded on sel_upd, is in step from the first symbol
			lfsr_nxt = LQT_SCR_SEED;
			prbs_nxt = LQT_PRBS_SEED;
			sym_cnt_nxt = '0;
			bs_cnt_nxt = '0;
		end else if (fire) begin
			prbs_nxt = prb[14:8];
			sym_cnt_nxt = (sym_cnt_r == LQT_BS_LAST) ? 13'h0 : sym_cnt_r + 13'h1;
			if (sym_ctrl && sym_data == LQT_SCR_RESET) begin
				lfsr_nxt = LQT_SCR_SEED;
				bs_cnt_nxt = '0;
			end else begin
				lfsr_nxt = scr[23:8];
				bs_cnt_nxt = sym_ctrl ? bs_cnt_r + 9'h1 : bs_cnt_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lfsr_r <= LQT_SCR_SEED;
			prbs_r <= LQT_PRBS_SEED;
			sym_cnt_r <= '0;
			bs_cnt_r <= '0;
		end else begin
			lfsr_r <= lfsr_nxt;
			prbs_r <= prbs_nxt;
			sym_cnt_r <= sym_cnt_nxt;
			bs_cnt_r <= bs_cnt_nxt;
		end
	end

	assign gen_if.valid = active;
	genvar g;
	generate
		for (g = 0; g < MAX_LANES; g++) begin : g_lane
			// idle lanes carry zeros so the phy can power them down
			assign gen_if.data[g*LQT_LANE_W +: LQT_LANE_W] =
				(3'(g) < lanes_r) ? {sym_ctrl, sym_data} : 9'h000;
			assign phy_data[g*LQT_SYM_W +: LQT_SYM_W] = out_if.data[g*LQT_LANE_W +: LQT_SYM_W];
			assign phy_ctrl[g] = out_if.data[g*LQT_LANE_W + LQT_SYM_W];
		end
	endgenerate

	lqt_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.wr(gen_if.snk),
		.rd(out_if.src)
	);
	assign out_if.ready = phy_ready;
	assign phy_valid = out_if.valid;
	assign sel_byte = sel_r;
	assign sel_upd = sel_upd_r;
	assign tally_req = req_r;
	assign tally_lane = lane_idx_r;
	assign ser_value = ser_r;
	assign ser_done = done_r;
	assign busy = busy_r;

	a_nyq_symbol: assert property (@(posedge clk) disable iff (reset)
		fire && mode_r == LQT_MODE_NYQ |-> sym_data == LQT_D10_2 && !sym_ctrl)
		else $error("nyquist symbol wrong");
	a_nyq_select: assert property (@(posedge clk) disable iff (reset)
		$rose(busy) && mode_r == LQT_MODE_NYQ |-> sel_byte[3:2] == 2'b01 && $past(sel_upd_nxt))
		else $error("nyquist not announced");
	a_sem_scrambled: assert property (@(posedge clk) disable iff (reset)
		fire && mode_r == LQT_MODE_SEM && !sym_ctrl |-> sym_data == (LQT_SEM_DATA ^ scr[7:0])
		##1 lfsr_r == $past(scr[23:8]))
		else $error("error pattern not scrambled zero");
	a_bs_period: assert property (@(posedge clk) disable iff (reset)
		fire && mode_r == LQT_MODE_SEM && sym_ctrl |-> sym_cnt_r == 13'h0
		##1 (sym_cnt_r == 13'h1 || !busy))
		else $error("blank start off period");
	a_sr_reset: assert property (@(posedge clk) disable iff (reset)
		fire && sym_ctrl && bs_cnt_r == LQT_SR_LAST && mode_r == LQT_MODE_SEM
		|-> sym_data == LQT_SCR_RESET ##1 lfsr_r == LQT_SCR_SEED && bs_cnt_r == 9'h0)
		else $error("scrambler reset symbol missing");
	a_tally_sum: assert property (@(posedge clk) disable iff (reset)
		state_r == LQT_READ && tally_valid && !stop |=> err_r == $past(err_r) + 32'($past(tally_value)))
		else $error("tally not accumulated");
	a_div_bound: assert property (@(posedge clk) disable iff (reset)
		$rose(state_r == LQT_DIV) && !stop |-> ##[72:73] (ser_done || !busy))
		else $error("rate not ready in time");
	a_lane_off: assert property (@(posedge clk) disable iff (reset)
		fire && lanes_r == 3'h1 && MAX_LANES > 1 |-> gen_if.data[WW-1:LQT_LANE_W] == '0)
		else $error("disabled lane not quiet");
	a_run_length: assert property (@(posedge clk) disable iff (reset)
		state_r == LQT_RUN && state_nxt == LQT_READ && !stop
		|-> cyc_r == 40'(MEASURE_CYCLES - 1))
		else $error("measurement period wrong");
endmodule // lqt_pattern_gen

// File: lqt_sink_model.sv
// behavioural sink receiver: descrambles each lane, counts errors, answers tally reads
`timescale 1ns/1ps
module lqt_sink_model import lqt_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [31:0] phy_data,
	input wire logic [3:0] phy_ctrl,
	input wire logic phy_valid,
	input wire logic phy_ready,
	input wire logic [7:0] sel_byte,
	input wire logic sel_upd,
	input wire logic tally_req,
	input wire logic [1:0] tally_lane,
	input wire logic [15:0] bias,
	input wire logic [1:0] delay,
	output logic tally_valid,
	output logic [15:0] tally_value,
	output logic blank_display
);
	logic [1:0] mode;
	logic [1:0] cnt;
	logic [15:0] scr;
	logic [15:0] nx;
	logic [7:0] mk;
	logic [15:0] err [4];
	// screen dark during the toggle pattern, receiver keeps running
	assign blank_display = (mode == LQT_MODE_NYQ);
	// inverted outside the pulse so a stale value never passes
	assign tally_value = tally_valid ? err[tally_lane] + bias : ~(err[tally_lane] + bias);
	always @(posedge clk) begin
		if (reset) begin
			mode <= LQT_MODE_OFF;
			scr <= 16'hFFFF;
			tally_valid <= 1'b0;
			cnt <= 2'h0;
			for (int i = 0; i < 4; i++) err[i] <= 16'h0000;
		end else begin
			if (sel_upd) begin
				mode <= sel_byte[3:2];
				scr <= 16'hFFFF;
				for (int i = 0; i < 4; i++) err[i] <= 16'h0000;
			end else if (phy_valid && phy_ready && mode == LQT_MODE_SEM) begin
				if (phy_ctrl[0] && phy_data[7:0] == 8'h1C) begin
					scr <= 16'hFFFF;
				end else begin
					nx = scr;
					for (int b = 0; b < 8; b++) begin
						mk[b] = nx[15];
						nx = {nx[14:0], 1'b0} ^ (nx[15] ? 16'h0039 : 16'h0000);
					end
					scr <= nx;
					// control symbols are framing, never errors
					for (int i = 0; i < 4; i++)
						if (!phy_ctrl[i] && phy_data[i*8+:8] != mk) err[i] <= err[i] + 16'h0001;
				end
			end
			if (tally_req && cnt == delay) begin
				tally_valid <= 1'b1;
				cnt <= 2'h0;
			end else begin
				tally_valid <= 1'b0;
				cnt <= tally_req ? cnt + 2'h1 : 2'h0;
			end
		end
	end
endmodule // lqt_sink_model

// File: lqt_pattern_gen_test.sv
// self-checking bench for the link quality test pattern source
`timescale 1ns/1ps
module lqt_pattern_gen_test import lqt_pkg::*; ;
	localparam longint MEAS = 9000;
	logic clk, reset, start, stop, rate_hbr, phy_valid, phy_ready, sel_upd, tally_req;
	logic tally_valid, ser_done, busy, hold, blank;
	logic [1:0] test_mode, tally_lane, dly;
	logic [2:0] lane_count;
	logic [31:0] phy_data, ser_value;
	logic [3:0] phy_ctrl;
	logic [7:0] sel_byte;
	logic [15:0] tally_value, bias;
	logic [35:0] qs[$];
	logic [7:0] qsel[$];
	logic [31:0] qser[$];
	int err_count = 0;
	int n_tests = 0;
	int cyc_cnt = 0;

	lqt_pattern_gen #(.MEASURE_CYCLES(MEAS)) i_lqt_pattern_gen (.clk(clk), .reset(reset),
		.start(start), .stop(stop), .test_mode(test_mode), .lane_count(lane_count),
		.rate_hbr(rate_hbr), .phy_data(phy_data), .phy_ctrl(phy_ctrl), .phy_valid(phy_valid),
		.phy_ready(phy_ready), .sel_byte(sel_byte), .sel_upd(sel_upd), .tally_req(tally_req),
		.tally_lane(tally_lane), .tally_valid(tally_valid), .tally_value(tally_value),
		.ser_value(ser_value), .ser_done(ser_done), .busy(busy));
	lqt_sink_model i_lqt_sink_model (.clk(clk), .reset(reset), .phy_data(phy_data),
		.phy_ctrl(phy_ctrl), .phy_valid(phy_valid), .phy_ready(phy_ready), .sel_byte(sel_byte),
		.sel_upd(sel_upd), .tally_req(tally_req), .tally_lane(tally_lane), .bias(bias),
		.delay(dly), .tally_valid(tally_valid), .tally_value(tally_value), .blank_display(blank));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// result monitor: every result takes the oldest note
	always @(posedge clk) begin
		if (!reset && phy_valid === 1'b1 && phy_ready && qs.size() > 0)
			chk("phy word", qs.pop_front(), {phy_ctrl, phy_data});
		if (!reset && sel_upd === 1'b1)
			chk("sel_byte", qsel.size() > 0 ? qsel.pop_front() : 'x, sel_byte);
		if (!reset && ser_done === 1'b1)
			chk("ser_value", qser.size() > 0 ? qser.pop_front() : 'x, ser_value);
	end

	// far side stalls now and then, and for long stretches on command
	always @(posedge clk) phy_ready <= !hold && ($urandom % 16 != 0);

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			err_count++;
			$display("CHECK FAILED timeout expected done seen hang");
			complete_run();
		end
	end

	task automatic try_bad(logic [1:0] m, logic [2:0] l);
		@(posedge clk);
		start <= 1'b1;
		test_mode <= m;
		lane_count <= l;
		@(posedge clk);
		start <= 1'b0;
		cyc(3);
		chk("busy refused", 0, busy);
	endtask

	task automatic run_test(string nm, logic [1:0] m, logic [2:0] l, logic h, int nw, logic [1:0] d);
		logic [15:0] s;
		logic [6:0] p;
		logic [7:0] b, mk;
		logic c;
		logic [35:0] wd;
		logic [15:0] bv;
		longint r;
		s = 16'hFFFF;
		p = 7'h7F;
		for (int w = 0; w < nw; w++) begin
			c = (m == LQT_MODE_SEM) && (w % 8192 == 0);
			for (int i = 0; i < 8; i++) begin
				mk[i] = s[15];
				s = {s[14:0], 1'b0} ^ (s[15] ? 16'h0039 : 16'h0000);
				b[i] = p[6] ^ p[5];
				p = {p[5:0], b[i]};
			end
			if (m == LQT_MODE_NYQ) b = 8'h4A;
			if (m == LQT_MODE_SEM) b = c ? 8'hBC : mk;
			wd = '0;
			for (int k = 0; k < l; k++) begin
				wd[k*8+:8] = b;
				wd[32+k] = c;
			end
			qs.push_back(wd);
		end
		bv = 16'($urandom % 1000);
		bias <= bv;
		dly <= d;
		r = longint'(l) * longint'(bv) * 64'd125000000000 / (MEAS * (h ? 270 : 162));
		if (r > 32'hFFFFFFFF) r = 32'hFFFFFFFF;
		if (m == LQT_MODE_SEM) qser.push_back(r[31:0]);
		qsel.push_back({4'h0, m, 2'h0});
		@(posedge clk);
		start <= 1'b1;
		test_mode <= m;
		lane_count <= l;
		rate_hbr <= h;
		@(posedge clk);
		start <= 1'b0;
		cyc(6);
		chk("blank display", m == LQT_MODE_NYQ, blank);
		// second start while busy must change nothing
		hold <= 1'b1;
		start <= 1'b1;
		test_mode <= LQT_MODE_PRBS;
		@(posedge clk);
		start <= 1'b0;
		cyc(12);
		hold <= 1'b0;
		while (qs.size() + qsel.size() + qser.size() > 0) @(posedge clk);
		qsel.push_back(8'h00);
		stop <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		cyc(20);
		qs.delete();
		chk("busy after stop", 0, busy);
		$display("test %s done", nm);
	endtask

	initial begin
		start = 1'b0;
		stop = 1'b0;
		test_mode = 2'h0;
		lane_count = 3'h1;
		rate_hbr = 1'b0;
		hold = 1'b0;
		phy_ready = 1'b0;
		bias = 16'h0000;
		dly = 2'h0;
		reset = 1'b1;
		void'($urandom(32'h0636));
		cyc(3);
		reset <= 1'b0;
		try_bad(LQT_MODE_OFF, 3'h4);
		try_bad(LQT_MODE_NYQ, 3'h0);
		try_bad(LQT_MODE_NYQ, 3'h5);
		$display("test refused starts done");
		run_test("nyquist", LQT_MODE_NYQ, 3'h4, 1'b1, 60, 2'h0);
		run_test("prbs7", LQT_MODE_PRBS, 3'h2, 1'b0, 200, 2'h0);
		run_test("error rate fast", LQT_MODE_SEM, 3'h4, 1'b1, 8200, 2'h0);
		run_test("error rate slow", LQT_MODE_SEM, 3'h1, 1'b0, 300, 2'h3);
		complete_run();
	end
endmodule // lqt_pattern_gen_test
